// file: core/dpr_pkg.sv
package dpr_pkg;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 18;
	localparam int BYTE_W = 9;
	localparam int DEPTH = 16384;
	localparam int NPORTS = 2;
	localparam int UPPER_LO = 9;
	localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 14'h0001;
	localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
	localparam logic LAT_FLOW = 1'b0;
	localparam logic LAT_PIPE = 1'b1;

	// synchronous inputs of one port, as presented before a rising edge
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic rw;
		logic chip_select_n;
		logic chip_select_p;
		logic upper_byte_sel_n;
		logic lower_byte_sel_n;
		logic address_strobe_n;
		logic count_enable_n;
		logic count_clear_n;
	} dpr_cmd_t;

	// access decoded from the inputs at the current edge
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic sel;
		logic rw;
		logic upper_n;
		logic lower_n;
	} dpr_acc_t;
endpackage

// file: core/dpr_port_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module dpr_port_ctl (
	input wire logic clock,
	input wire logic reset,
	input wire logic clock_en,
	input wire dpr_pkg::dpr_cmd_t cmd,
	output var dpr_pkg::dpr_acc_t acc
);
	logic [dpr_pkg::ADDR_W-1:0] addr_q;
	logic [dpr_pkg::ADDR_W-1:0] addr_d;

	always_comb
	begin
		if (!cmd.count_clear_n)
			addr_d = dpr_pkg::ADDR_RST;
		else if (!cmd.address_strobe_n)
			addr_d = cmd.addr;
		else if (!cmd.count_enable_n)
			addr_d = addr_q + dpr_pkg::ADDR_STEP;
		else
			addr_d = addr_q;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			addr_q <= dpr_pkg::ADDR_RST;
		else if (clock_en)
			addr_q <= addr_d;
	end

	always_comb
	begin
		acc.addr = addr_d;
		acc.wdata = cmd.wdata;
		// both chip selects must be active
		acc.sel = !cmd.chip_select_n && cmd.chip_select_p;
		acc.rw = cmd.rw;
		acc.upper_n = cmd.upper_byte_sel_n;
		acc.lower_n = cmd.lower_byte_sel_n;
	end

	a_count_clear: assert property (@(posedge clock) disable iff (reset)
		clock_en && !cmd.count_clear_n |=> addr_q == dpr_pkg::ADDR_RST)
		else $error("counter clear did not reach zero");
	a_addr_load: assert property (@(posedge clock) disable iff (reset)
		clock_en && cmd.count_clear_n && !cmd.address_strobe_n
		|=> addr_q == $past(cmd.addr))
		else $error("strobed address not loaded");
	a_count_inc: assert property (@(posedge clock) disable iff (reset)
		clock_en && cmd.count_clear_n && cmd.address_strobe_n && !cmd.count_enable_n
		|=> addr_q == $past(addr_q) + dpr_pkg::ADDR_STEP)
		else $error("counter did not advance by one");
	a_count_hold: assert property (@(posedge clock) disable iff (reset)
		(clock_en && cmd.count_clear_n && cmd.address_strobe_n && cmd.count_enable_n)
		or !clock_en |=> $stable(addr_q))
		else $error("held address changed");
endmodule
`default_nettype wire

// file: core/dpr_ram.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - both ports reach any word at once, same address included
// - memory holds 16384 words of 18 bits, 14-bit address per port
// - address, write data and controls are captured at the rising edge
// - port deselected, lanes off and standby, unless both chip selects active
// - chip selects take one stage in flow-through, two in pipelined
// - byte selects take one register stage in either latency mode
// - write stores only the bytes whose select is low
// - read drives only lanes whose byte select is low
// - output enable high turns both lanes off at once, unclocked
// - each port picks its own read latency
// - latency select low is flow-through, high is pipelined, static level
// - pipelined read data comes one cycle after flow-through data
// - strobe low loads the external address and uses it now
// - count enable low increments the counter, selects regardless
// - strobe and count enable high reuse the held address
// - clear low forces address zero over strobe and count enable
// - load and clear work whatever the chip and byte selects
module dpr_ram (
	input wire logic clock,
	input wire logic reset,
	input wire logic clock_en,
	input wire dpr_pkg::dpr_cmd_t left_cmd,
	input wire logic left_oe_n,
	input wire logic left_output_latency_select,
	output logic [dpr_pkg::DATA_W-1:0] left_data_out,
	output logic [1:0] left_data_oe_n,
	output logic left_standby,
	input wire dpr_pkg::dpr_cmd_t right_cmd,
	input wire logic right_oe_n,
	input wire logic right_output_latency_select,
	output logic [dpr_pkg::DATA_W-1:0] right_data_out,
	output logic [1:0] right_data_oe_n,
	output logic right_standby
);
	localparam int NP = dpr_pkg::NPORTS;
	localparam int BW = dpr_pkg::BYTE_W;
	localparam int UL = dpr_pkg::UPPER_LO;

	logic [dpr_pkg::DATA_W-1:0] mem [dpr_pkg::DEPTH];
	dpr_pkg::dpr_cmd_t cmd [NP];
	dpr_pkg::dpr_acc_t acc [NP];
	logic oe_n [NP];
	logic lat [NP];
	logic [1:0] we [NP];
	logic [dpr_pkg::DATA_W-1:0] rd_word [NP];
	logic [dpr_pkg::DATA_W-1:0] flow_q [NP];
	logic [dpr_pkg::DATA_W-1:0] data_q [NP];
	logic rd1_q [NP];
	logic sel1_q [NP];
	logic [1:0] drive_q [NP];
	logic standby_q [NP];

	assign cmd[0] = left_cmd;
	assign cmd[1] = right_cmd;
	assign oe_n[0] = left_oe_n;
	assign oe_n[1] = right_oe_n;
	// latency pin is a static level
	assign lat[0] = left_output_latency_select;
	assign lat[1] = right_output_latency_select;

	for (genvar p = 0; p < NP; p++)
	begin : g_port
		logic rd_now;
		logic rd_stage;

		dpr_port_ctl u_ctl (
			.clock(clock),
			.reset(reset),
			.clock_en(clock_en),
			.cmd(cmd[p]),
			.acc(acc[p])
		);

		assign we[p][1] = acc[p].sel && !acc[p].rw && !acc[p].upper_n;
		assign we[p][0] = acc[p].sel && !acc[p].rw && !acc[p].lower_n;
		// each port reads the array on its own
		assign rd_word[p] = mem[acc[p].addr];
		assign rd_now = acc[p].sel && acc[p].rw;
		// pipelined read enable passes one extra stage
		assign rd_stage = (lat[p] == dpr_pkg::LAT_PIPE) ? rd1_q[p] : rd_now;

		always_ff @(posedge clock)
		begin
			if (reset)
			begin
				rd1_q[p] <= 1'b0;
				sel1_q[p] <= 1'b0;
			end
			else if (clock_en)
			begin
				rd1_q[p] <= rd_now;
				sel1_q[p] <= acc[p].sel;
			end
		end

		// pipelined data is one cycle behind flow-through
		always_ff @(posedge clock)
		begin
			if (reset)
			begin
				flow_q[p] <= dpr_pkg::DATA_RST;
				data_q[p] <= dpr_pkg::DATA_RST;
			end
			else if (clock_en)
			begin
				flow_q[p] <= rd_word[p];
				data_q[p] <= (lat[p] == dpr_pkg::LAT_PIPE) ? flow_q[p] : rd_word[p];
			end
		end

		always_ff @(posedge clock)
		begin
			if (reset)
				drive_q[p] <= 2'b00;
			else if (clock_en)
				drive_q[p] <= {rd_stage && !acc[p].upper_n, rd_stage && !acc[p].lower_n};
		end

		always_ff @(posedge clock)
		begin
			if (reset)
				standby_q[p] <= 1'b1;
			else if (clock_en)
				standby_q[p] <= (lat[p] == dpr_pkg::LAT_PIPE) ? !sel1_q[p] : !acc[p].sel;
		end

		// only reads are compared: unwritten words of the array are unknown
		a_flow_latency: assert property (@(posedge clock) disable iff (reset)
			clock_en && $past(clock_en) && $past(rd_now) && lat[p] == dpr_pkg::LAT_FLOW
			&& $stable(lat[p]) |-> data_q[p] == $past(rd_word[p]))
			else $error("flow-through data not one cycle after access");
		a_pipe_latency: assert property (@(posedge clock) disable iff (reset)
			clock_en && $past(clock_en) && $past(clock_en, 2) && $past(rd_now, 2)
			&& lat[p] == dpr_pkg::LAT_PIPE && $past(lat[p]) == dpr_pkg::LAT_PIPE
			|-> data_q[p] == $past(rd_word[p], 2))
			else $error("pipelined data not two cycles after access");
		a_pipe_deselect: assert property (@(posedge clock) disable iff (reset)
			clock_en && lat[p] == dpr_pkg::LAT_PIPE && !acc[p].sel
			##1 clock_en && lat[p] == dpr_pkg::LAT_PIPE |=> standby_q[p])
			else $error("pipelined deselect did not reach standby in two cycles");
		a_flow_deselect: assert property (@(posedge clock) disable iff (reset)
			clock_en && lat[p] == dpr_pkg::LAT_FLOW && !acc[p].sel
			|=> standby_q[p] && drive_q[p] == 2'b00)
			else $error("flow-through deselect did not stop the port");
		a_flow_standby: assert property (@(posedge clock) disable iff (reset)
			clock_en && lat[p] == dpr_pkg::LAT_FLOW && acc[p].sel
			|=> !standby_q[p])
			else $error("selected flow-through port left in standby");
		a_reset_standby: assert property (@(posedge clock)
			reset |=> standby_q[p] && drive_q[p] == 2'b00 && data_q[p] == dpr_pkg::DATA_RST)
			else $error("reset did not park the port");
		// pipelined read stage comes from the previous edge, byte select from this one
		a_lane_select: assert property (@(posedge clock) disable iff (reset)
			clock_en && (acc[p].upper_n
			|| (lat[p] == dpr_pkg::LAT_FLOW && !(acc[p].sel && acc[p].rw))
			|| (lat[p] == dpr_pkg::LAT_PIPE && $past(clock_en)
			&& !$past(acc[p].sel && acc[p].rw)))
			|=> !drive_q[p][1])
			else $error("upper lane driven without its select");
		a_lower_select: assert property (@(posedge clock) disable iff (reset)
			clock_en && (acc[p].lower_n
			|| (lat[p] == dpr_pkg::LAT_FLOW && !(acc[p].sel && acc[p].rw))
			|| (lat[p] == dpr_pkg::LAT_PIPE && $past(clock_en)
			&& !$past(acc[p].sel && acc[p].rw)))
			|=> !drive_q[p][0])
			else $error("lower lane driven without its select");
		a_flow_read: assert property (@(posedge clock) disable iff (reset)
			clock_en && lat[p] == dpr_pkg::LAT_FLOW && rd_now && !acc[p].lower_n
			|=> drive_q[p][0])
			else $error("selected lower lane not driven on read");
		a_pipe_read: assert property (@(posedge clock) disable iff (reset)
			clock_en && lat[p] == dpr_pkg::LAT_PIPE && rd_now
			##1 clock_en && lat[p] == dpr_pkg::LAT_PIPE && !acc[p].lower_n
			|=> drive_q[p][0])
			else $error("pipelined lower lane not driven on read");
		a_no_write: assert property (@(posedge clock) disable iff (reset)
			clock_en && !cmd[p].rw && cmd[p].upper_byte_sel_n && cmd[p].lower_byte_sel_n
			|-> we[p] == 2'b00)
			else $error("write with both bytes deselected");
	end

	// write data taken at the edge
	always_ff @(posedge clock)
	begin
		if (clock_en)
		begin
			for (int p = 0; p < NP; p++)
			begin
				if (we[p][1])
					mem[acc[p].addr][UL +: BW] <= acc[p].wdata[UL +: BW];
				if (we[p][0])
					mem[acc[p].addr][0 +: BW] <= acc[p].wdata[0 +: BW];
			end
		end
	end

	a_write_store: assert property (@(posedge clock) disable iff (reset)
		clock_en && we[0] == 2'b11 && we[1] == 2'b00
		|=> mem[$past(acc[0].addr)] == $past(acc[0].wdata))
		else $error("left write not stored");
	// right port wins a same-word clash, so its store needs no guard on the left
	a_right_store: assert property (@(posedge clock) disable iff (reset)
		clock_en && we[1] == 2'b11
		|=> mem[$past(acc[1].addr)] == $past(acc[1].wdata))
		else $error("right write not stored");
	a_keep_upper: assert property (@(posedge clock) disable iff (reset)
		clock_en && we[1] == 2'b01 && we[0] == 2'b00
		|=> mem[$past(acc[1].addr)][UL +: BW] == $past(mem[acc[1].addr][UL +: BW]))
		else $error("lower-only write changed the upper byte");

	assign left_data_out = data_q[0];
	assign right_data_out = data_q[1];
	assign left_standby = standby_q[0];
	assign right_standby = standby_q[1];
	// output enable gates lanes without a clock
	assign left_data_oe_n = ~drive_q[0] | {2{oe_n[0]}};
	assign right_data_oe_n = ~drive_q[1] | {2{oe_n[1]}};

	a_oe_off: assert property (@(posedge clock) disable iff (reset)
		left_oe_n |-> left_data_oe_n == 2'b11)
		else $error("left lanes on while output enable high");
	a_right_oe_off: assert property (@(posedge clock) disable iff (reset)
		right_oe_n |-> right_data_oe_n == 2'b11)
		else $error("right lanes on while output enable high");
endmodule
`default_nettype wire

// file: verification/dpr_host.sv
`timescale 1ns/10ps
`default_nettype none
module dpr_host (
	input wire logic clock,
	output var dpr_pkg::dpr_cmd_t cmd
);
	// ctl bits: rw, cs_n, cs_p, ub_n, lb_n, strobe_n, count_en_n, clear_n
	initial cmd = {14'h0000, 18'h00000, 8'hdf};
	task automatic cyc(input logic [13:0] a, input logic [17:0] d, input logic [7:0] c);
		@(negedge clock);
		cmd <= {a, d, c};
	endtask
	// released bus shows the inverse of its last value
	task automatic idle();
		cyc(~cmd.addr, ~cmd.wdata, 8'hdf);
	endtask
	task automatic wr(input logic [13:0] a, input logic [17:0] d, input logic [1:0] bs);
		cyc(a, ~d, 8'hc3);
		cyc(~a, d, {3'b001, bs, 3'b111});
	endtask
endmodule
`default_nettype wire

// file: verification/dpr_ram_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dpr_ram_tb;
	logic clock = 0;
	logic reset = 1;
	logic lat = 0;
	logic oe_n = 0;
	int err_count = 0;
	int samples_checked = 0;
	int cyc_n = 0;
	int seed = 32'hc74d4a25;
	logic [17:0] mem [16384];
	logic [35:0] notes [$];
	dpr_pkg::dpr_cmd_t lc;
	dpr_pkg::dpr_cmd_t rc;
	logic [17:0] ld;
	logic [1:0] loe;
	logic lsb;
	logic [17:0] rdo;
	logic [1:0] roe;
	logic rsb;
	dpr_host hl (.clock(clock), .cmd(lc));
	dpr_host hr (.clock(clock), .cmd(rc));
	dpr_ram uut (.clock(clock), .reset(reset), .clock_en(1'b1), .left_cmd(lc),
		.left_oe_n(oe_n), .left_output_latency_select(lat), .left_data_out(ld),
		.left_data_oe_n(loe), .left_standby(lsb), .right_cmd(rc), .right_oe_n(oe_n),
		.right_output_latency_select(~lat), .right_data_out(rdo), .right_data_oe_n(roe),
		.right_standby(rsb));
	initial forever #20 clock = ~clock;
	always @(posedge clock) cyc_n <= cyc_n + 1;
	task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
		samples_checked++;
		if (s !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	function automatic logic [17:0] lanes(input logic [1:0] o, input logic [17:0] d);
		return d & {{9{~o[1]}}, {9{~o[0]}}};
	endfunction
	// read one word on the left and note its lanes and arrival cycle
	task automatic rd_note(input logic [13:0] a, input logic [13:0] ea, input logic [1:0] bs,
		input logic [2:0] ac);
		hl.cyc(a, 18'($random(seed)), {3'b101, bs, ac});
		if (bs != 2'b11 && !oe_n)
			notes.push_back({16'(cyc_n + 1 + lat), bs, lanes(bs, mem[ea])});
	endtask
	always @(negedge clock)
		if (!reset && loe !== 2'b11)
		begin
			if (notes.size() == 0)
				chk("stray drive", 36'h0, {16'(cyc_n), loe, ld});
			else
				chk("read", notes.pop_front(), {16'(cyc_n), loe, lanes(loe, ld)});
		end
	initial
	begin
		#100000;
		err_count++;
		stop_test();
	end
	initial
	begin
		logic [13:0] a;
		logic [13:0] b;
		logic [17:0] d;
		logic [17:0] d2;
		logic [1:0] bs;
		logic [1:0] rb;
		repeat (4) @(posedge clock);
		@(negedge clock) reset <= 0;
		@(negedge clock);
		chk("standby", 36'h1, {35'h0, lsb});
		// one full-word write from the left port, then release it
		hl.wr(14'h0000, 18'($random(seed)), 2'b00);
		hl.idle();
		for (int i = 0; i < 8; i++)
		begin
			a = (i == 0) ? 14'h3fff : 14'($random(seed));
			b = a + 14'h0001;
			d = 18'($random(seed));
			d2 = {d[8:0], d[17:9]};
			bs = 2'(i);
			rb = (i[2:1] == 2'b11) ? 2'b00 : 2'(i >> 1);
			lat <= i[0];
			oe_n <= (i == 3);
			hr.wr(a, ~d, 2'b00);
			hr.wr(b, d, 2'b00);
			hr.wr(a, d2, bs);
			// right read of b, flow-through when lat is high, pipelined otherwise
			hr.cyc(b, 18'($random(seed)), {3'b101, 2'b00, 3'b011});
			@(posedge clock);
			#1 chk("right first", {15'h0, 1'b0, {2{~lat | oe_n}}, lanes({2{~lat | oe_n}}, d)},
				{15'h0, rsb, roe, lanes(roe, rdo)});
			@(posedge clock);
			#1 chk("right second", {15'h0, 1'b0, {2{oe_n}}, lanes({2{oe_n}}, d)},
				{15'h0, rsb, roe, lanes(roe, rdo)});
			hr.idle();
			mem[a] = ~d;
			mem[b] = d;
			mem[a] = lanes(~bs, mem[a]) | lanes(bs, d2);
			rd_note(a, a, rb, 3'b011);
			rd_note(~a, b, rb, 3'b101);
			rd_note(a, 14'h0000, rb, 3'b000);
			hl.cyc(~a, 18'h00000, {3'b110, rb, 3'b111});
			@(posedge clock);
			#1 chk("deselect", {35'h0, ~lat}, {35'h0, lsb});
			hl.idle();
			hl.idle();
		end
		repeat (3) @(negedge clock);
		chk("notes left", 36'h0, 36'(notes.size()));
		stop_test();
	end
endmodule
`default_nettype wire
